// *** common/ddb_pkg.sv ***
// Constants, field layouts and state codes for the dual operand decoder
// Notes on behaviour
// RULE_01 - Byte operands zero extended to sixteen bits
// RULE_02 - Copy writes source, flags untouched
// RULE_03 - Sum stores dst plus src, four flags
// RULE_04 - Sum with carry adds carry flag too
// RULE_05 - Difference stores dst minus src, borrow flag
// RULE_06 - Difference with borrow subtracts carry flag too
// RULE_07 - Compare subtracts, sets flags, discards result
// RULE_08 - Bitwise and stores, null and sign
// RULE_09 - Mask probe ands, flags only, discards
// RULE_10 - Bitwise or stores, null and sign
// RULE_11 - Bitwise xor stores, null and sign
// RULE_12 - Relative jump adds twice signed offset
// RULE_13 - Absolute jump loads destination operand
// RULE_14 - Return pops program counter from stack
// RULE_15 - Call pushes return address, loads destination
// RULE_16 - Soft trap pushes, loads doubled vector
// RULE_17 - Software avoids trap vectors zero to 31
// RULE_18 - Codes 0..7 test single flag set/clear
// RULE_19 - Codes 8,9 combine null and carry
// RULE_20 - Codes 10..13 signed compare predicates
// RULE_21 - Code 15 always true
// RULE_22 - False predicate: next instruction, no changes
// RULE_23 - Flags word layout, null on zero
// RULE_24 - Opcode, source, destination field positions
// RULE_25 - Stack indirect write predecrements, read postincrements
package ddb_pkg;

  // Instruction field positions
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 12;
  localparam int SRC_HI = 11;
  localparam int SRC_LO = 6;
  localparam int DST_HI = 5;
  localparam int DST_LO = 0;
  localparam int CC_HI  = 11;
  localparam int CC_LO  = 8;

  // Major opcodes
  localparam logic [3:0] OP_COPY  = 4'h0;
  localparam logic [3:0] OP_SUM   = 4'h1;
  localparam logic [3:0] OP_SUMC  = 4'h2;
  localparam logic [3:0] OP_DIFF  = 4'h3;
  localparam logic [3:0] OP_DIFFB = 4'h4;
  localparam logic [3:0] OP_CMP   = 4'h5;
  localparam logic [3:0] OP_AND   = 4'h6;
  localparam logic [3:0] OP_PROBE = 4'h7;
  localparam logic [3:0] OP_OR    = 4'h8;
  localparam logic [3:0] OP_XOR   = 4'h9;
  localparam logic [3:0] OP_CALLT = 4'hA;
  localparam logic [3:0] OP_JUMP  = 4'hC;

  // Program control sub-format code in bits 7..6, trap predicate code in bits 11..8
  localparam logic [1:0] FMT_ABS  = 2'h2;
  localparam logic [3:0] CC_TRAP  = 4'h0;

  // Operand field for word indirect through the stack pointer
  localparam logic [5:0] FLD_SP_IND = 6'h17;

  // Flags word bit positions
  localparam int FL_NULL  = 0;
  localparam int FL_WRAP  = 1;
  localparam int FL_RANGE = 2;
  localparam int FL_NEG   = 3;
  localparam int FL_IEN   = 4;
  localparam int FL_W     = 5;
  localparam logic [FL_W-1:0] FLAGS_RST = 5'h00;

  // Predicate codes
  localparam logic [3:0] CC_NZ_NC = 4'h8;
  localparam logic [3:0] CC_Z_OR_C = 4'h9;
  localparam logic [3:0] CC_GT    = 4'hA;
  localparam logic [3:0] CC_GE    = 4'hB;
  localparam logic [3:0] CC_LT    = 4'hC;
  localparam logic [3:0] CC_LE    = 4'hD;
  localparam logic [3:0] CC_UNUSED = 4'hE;
  localparam logic [3:0] CC_ALWAYS = 4'hF;

  // Byte step of one stack word, and mask for byte operands
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_MASK = 16'h00FF;

  // Reset values of program counter and stack pointer
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;

  // Execution sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_POP  = 2'b10,
    ST_VEC  = 2'b11
  } ddb_state_t;

endpackage

// *** hdl/ddb_cond_eval.sv ***
// Branch predicate evaluation against the flags word
`timescale 1ns/1ps
`default_nettype none
module ddb_cond_eval
  import ddb_pkg::*;
(
  input  wire logic [3:0]      code_i,  // Predicate code
  input  wire logic [FL_W-1:0] flags_i, // Current flags word
  output logic                 taken_o  // Predicate holds
);

  // Individual flags
  wire z = flags_i[FL_NULL];
  wire c = flags_i[FL_WRAP];
  wire o = flags_i[FL_RANGE];
  wire s = flags_i[FL_NEG];

  // Even codes test set, odd codes test clear
  wire [3:0] single = {o, s, c, z};
  wire       pair_hit = single[code_i[2:1]] ^ code_i[0]; // [RULE_18]

  // Code table; the unused code never takes the branch
  always_comb begin
    unique case (code_i)
      CC_NZ_NC:  taken_o = ~z & ~c;        // [RULE_19]
      CC_Z_OR_C: taken_o = z | c;          // [RULE_19]
      CC_GT:     taken_o = (o == s) & ~z;  // [RULE_20]
      CC_GE:     taken_o = (o == s);       // [RULE_20]
      CC_LT:     taken_o = (o != s);       // [RULE_20]
      CC_LE:     taken_o = (o != s) | z;   // [RULE_20]
      CC_UNUSED: taken_o = 1'b0;           // [RULE_18]
      CC_ALWAYS: taken_o = 1'b1;           // [RULE_21]
      default:   taken_o = pair_hit;       // [RULE_18]
    endcase
  end

endmodule
`default_nettype wire

// *** hdl/ddb_exec.sv ***
// Execute unit for two-operand and program control instructions
`timescale 1ns/1ps
`default_nettype none
module ddb_exec
  import ddb_pkg::*;
(
  input  wire logic        clock_i,       // 100 MHz core clock
  input  wire logic        rst_b_i,       // Async reset, active low
  input  wire logic        instr_valid_i, // Instruction and operands valid
  output logic             instr_ready_o, // Ready for next instruction
  input  wire logic [15:0] instr_i,       // Instruction word
  input  wire logic [1:0]  instr_len_i,   // Length in words, with extensions
  input  wire logic [15:0] src_val_i,     // Resolved source operand
  input  wire logic [15:0] dst_val_i,     // Resolved destination operand
  input  wire logic        src_byte_i,    // Source is byte wide
  input  wire logic        dst_byte_i,    // Destination is byte wide
  output logic             mem_req_o,     // Stack memory request
  output logic             mem_we_o,      // Stack memory write
  output logic [15:0]      mem_addr_o,    // Stack memory byte address
  output logic [15:0]      mem_wdata_o,   // Stack memory write data
  input  wire logic        mem_ack_i,     // Stack memory access done
  input  wire logic [15:0] mem_rdata_i,   // Stack memory read data
  output logic             res_we_o,      // Destination write strobe
  output logic [15:0]      res_data_o,    // Destination write value
  output logic             done_o,        // Instruction retired
  output logic [15:0]      pc_o,          // Program counter
  output logic [15:0]      sp_o,          // Stack pointer
  output logic [15:0]      flags_o        // Flags word
);

  // Architectural state
  ddb_state_t      state_reg;   // Sequencer state
  ddb_state_t      state_next;
  logic [15:0]     pc_reg;      // Program counter
  logic [15:0]     pc_next;
  logic [15:0]     sp_reg;      // Stack pointer
  logic [15:0]     sp_next;
  logic [FL_W-1:0] flags_reg;   // Flags
  logic [FL_W-1:0] flags_next;
  logic [15:0]     target_reg;  // Pending jump target
  logic [15:0]     target_next;
  logic            res_we_reg;  // Result strobe
  logic            res_we_next;
  logic [15:0]     res_reg;     // Result value
  logic [15:0]     res_next;
  logic            done_reg;    // Retire pulse
  logic            done_next;
  logic            trap_reg;    // Pending push belongs to a soft trap
  logic            trap_next;

  // Field decode, bit positions fixed by the format [RULE_24]
  wire [3:0] opc      = instr_i[OPC_HI:OPC_LO];
  wire [5:0] src_fld  = instr_i[SRC_HI:SRC_LO];
  wire [5:0] dst_fld  = instr_i[DST_HI:DST_LO];
  wire [3:0] cc       = instr_i[CC_HI:CC_LO];
  wire [1:0] fmt      = instr_i[7:6];
  wire [6:0] rel_off  = instr_i[6:0];

  // Class decode
  wire is_alu    = (opc <= OP_XOR);
  wire is_jump   = (opc == OP_JUMP);
  wire is_rel    = is_jump & ~instr_i[7];
  wire is_abs    = is_jump & (fmt == FMT_ABS) & (dst_fld != FLD_SP_IND);
  wire is_ret    = is_jump & (fmt == FMT_ABS) & (dst_fld == FLD_SP_IND);
  wire is_call   = (opc == OP_CALLT) & (fmt == FMT_ABS);
  wire is_trap   = (opc == OP_CALLT) & ~instr_i[7] & (cc == CC_TRAP);
  wire accept    = instr_valid_i & (state_reg == ST_IDLE);

  // Byte operands widened with zeros in the upper half [RULE_01]
  wire [15:0] src_w = src_byte_i ? (src_val_i & BYTE_MASK) : src_val_i;
  wire [15:0] dst_w = dst_byte_i ? (dst_val_i & BYTE_MASK) : dst_val_i;

  // Carry in for the chained forms
  wire        cin     = flags_reg[FL_WRAP];
  wire        use_cin = (opc == OP_SUMC) | (opc == OP_DIFFB);

  // Seventeen bit adder and subtractor; bit 16 is carry or borrow
  wire [16:0] sum17  = {1'b0, dst_w} + {1'b0, src_w}
                     + {16'h0000, use_cin & cin};   // [RULE_03] [RULE_04]
  wire [16:0] diff17 = {1'b0, dst_w} - {1'b0, src_w}
                     - {16'h0000, use_cin & cin};   // [RULE_05] [RULE_06]

  // Sign overflow: equal signs in that flip for add, unlike for subtract
  wire add_ovf = (dst_w[15] == src_w[15]) & (sum17[15] != dst_w[15]);
  wire sub_ovf = (dst_w[15] != src_w[15]) & (diff17[15] != dst_w[15]);

  // Sequential address skips every extension word [RULE_22]
  wire [15:0] seq_pc = pc_reg + {13'h0000, instr_len_i, 1'b0};

  // Relative target: offset sign extended then doubled [RULE_12]
  wire [15:0] rel_pc = seq_pc + {{8{rel_off[6]}}, rel_off, 1'b0};

  // Trap vector address: number doubled, zero extended [RULE_16]
  wire [15:0] vec_addr = {8'h00, rel_off, 1'b0};

  // Predicate check
  logic taken;
  ddb_cond_eval u_cond (
    .code_i  (cc),
    .flags_i (flags_reg),
    .taken_o (taken)
  );

  // Logic unit result per opcode
  logic [15:0] alu_res;
  logic        alu_wr;   // Result goes to destination
  logic        alu_arith; // Carry and overflow updated
  logic        alu_flags; // Null and sign updated
  logic        alu_c;
  logic        alu_o;
  always_comb begin
    alu_res   = 16'h0000;
    alu_wr    = 1'b0;
    alu_arith = 1'b0;
    alu_flags = 1'b0;
    alu_c     = 1'b0;
    alu_o     = 1'b0;
    unique case (opc)
      OP_COPY: begin
        // Plain copy leaves every flag alone
        alu_res = src_w;                           // [RULE_02]
        alu_wr  = 1'b1;
      end
      OP_SUM, OP_SUMC: begin
        alu_res   = sum17[15:0];                   // [RULE_03] [RULE_04]
        alu_wr    = 1'b1;
        alu_arith = 1'b1;
        alu_flags = 1'b1;
        alu_c     = sum17[16];
        alu_o     = add_ovf;
      end
      OP_DIFF, OP_DIFFB, OP_CMP: begin
        // Compare is a subtraction whose result is dropped
        alu_res   = diff17[15:0];                  // [RULE_05] [RULE_06]
        alu_wr    = (opc != OP_CMP);               // [RULE_07]
        alu_arith = 1'b1;
        alu_flags = 1'b1;
        alu_c     = diff17[16];
        alu_o     = sub_ovf;
      end
      OP_AND, OP_PROBE: begin
        alu_res   = dst_w & src_w;                 // [RULE_08]
        alu_wr    = (opc == OP_AND);               // [RULE_09]
        alu_flags = 1'b1;
      end
      OP_OR: begin
        alu_res   = dst_w | src_w;                 // [RULE_10]
        alu_wr    = 1'b1;
        alu_flags = 1'b1;
      end
      OP_XOR: begin
        alu_res   = dst_w ^ src_w;                 // [RULE_11]
        alu_wr    = 1'b1;
        alu_flags = 1'b1;
      end
      default: begin
        // Program control opcodes do not use the logic unit
        alu_wr = 1'b0;
      end
    endcase
  end

  // Flags after a logic unit operation, laid out per flags word [RULE_23]
  logic [FL_W-1:0] alu_fl;
  always_comb begin
    alu_fl = flags_reg;
    if (alu_flags) begin
      alu_fl[FL_NULL] = (alu_res == 16'h0000);     // [RULE_23]
      alu_fl[FL_NEG]  = alu_res[15];
    end
    if (alu_arith) begin
      alu_fl[FL_WRAP]  = alu_c;                    // [RULE_05]
      alu_fl[FL_RANGE] = alu_o;
    end
  end

  // Stack pointer through an operand: pop on source read, push on a
  // storing destination [RULE_25]
  wire        src_pop  = (src_fld == FLD_SP_IND);
  wire        dst_push = (dst_fld == FLD_SP_IND) & alu_wr;
  wire [15:0] sp_pop   = src_pop ? (sp_reg + WORD_STEP) : sp_reg;
  wire [15:0] sp_alu   = dst_push ? (sp_pop - WORD_STEP) : sp_pop;

  // Push address for call and trap: stack pointer after predecrement
  wire [15:0] sp_dec = sp_reg - WORD_STEP;

  // Sequencer next state and architectural updates
  always_comb begin
    state_next  = state_reg;
    pc_next     = pc_reg;
    sp_next     = sp_reg;
    flags_next  = flags_reg;
    target_next = target_reg;
    res_we_next = 1'b0;
    res_next    = res_reg;
    done_next   = 1'b0;
    trap_next   = trap_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          if (is_alu) begin
            // One cycle retire for two-operand forms
            flags_next  = alu_fl;
            res_next    = alu_res;
            res_we_next = alu_wr;
            sp_next     = sp_alu;                  // [RULE_25]
            pc_next     = seq_pc;
            done_next   = 1'b1;
          end else if (is_trap) begin
            // Trap is unconditional; push then fetch the vector
            sp_next     = sp_dec;                  // [RULE_16]
            pc_next     = seq_pc;
            target_next = vec_addr;
            trap_next   = 1'b1;
            state_next  = ST_PUSH;
          end else if (!taken) begin
            // Failed predicate: fall through, state kept [RULE_22]
            pc_next   = seq_pc;
            done_next = 1'b1;
          end else if (is_rel) begin
            pc_next   = rel_pc;                    // [RULE_12]
            done_next = 1'b1;
          end else if (is_abs) begin
            pc_next   = dst_val_i;                 // [RULE_13]
            done_next = 1'b1;
          end else if (is_ret) begin
            state_next = ST_POP;                   // [RULE_14]
          end else if (is_call) begin
            // Return address is the word after any extension
            sp_next     = sp_dec;                  // [RULE_15]
            pc_next     = seq_pc;
            target_next = dst_val_i;
            trap_next   = 1'b0;
            state_next  = ST_PUSH;
          end else begin
            // Forms outside this unit retire as no operation
            pc_next   = seq_pc;
            done_next = 1'b1;
          end
        end
      end
      ST_PUSH: begin
        // Return address written at the new stack top
        if (mem_ack_i) begin
          // Kept in a flop: the word need not stand after the take
          if (trap_reg) begin
            state_next = ST_VEC;                   // [RULE_16]
          end else begin
            pc_next    = target_reg;               // [RULE_15]
            done_next  = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      ST_POP: begin
        // Pop: read at the stack top, then step past it
        if (mem_ack_i) begin
          pc_next    = mem_rdata_i;                // [RULE_14]
          sp_next    = sp_reg + WORD_STEP;         // [RULE_14]
          done_next  = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_VEC: begin
        // Vector table entry becomes the new program counter
        if (mem_ack_i) begin
          pc_next    = mem_rdata_i;                // [RULE_16]
          done_next  = 1'b1;
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // Stack memory port: decoded from the sequencer state
  wire in_push = (state_reg == ST_PUSH);
  wire in_vec  = (state_reg == ST_VEC);
  assign mem_req_o   = (state_reg != ST_IDLE);
  assign mem_we_o    = in_push;
  assign mem_addr_o  = in_vec ? target_reg : sp_reg;
  assign mem_wdata_o = pc_reg;

  // Instruction taken only while the sequencer is free
  assign instr_ready_o = (state_reg == ST_IDLE);

  // State registers
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg  <= ST_IDLE;
      pc_reg     <= PC_RST;
      sp_reg     <= SP_RST;
      flags_reg  <= FLAGS_RST;
      target_reg <= 16'h0000;
      trap_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      pc_reg     <= pc_next;
      sp_reg     <= sp_next;
      flags_reg  <= flags_next;
      target_reg <= target_next;
      trap_reg   <= trap_next;
    end
  end

  // Result and retire strobes, held in flops so outputs are clean
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      res_we_reg <= 1'b0;
      res_reg    <= 16'h0000;
      done_reg   <= 1'b0;
    end else begin
      res_we_reg <= res_we_next;
      res_reg    <= res_next;
      done_reg   <= done_next;
    end
  end

  // Output drive; upper flags bits always read zero
  assign res_we_o   = res_we_reg;
  assign res_data_o = res_reg;
  assign done_o     = done_reg;
  assign pc_o       = pc_reg;
  assign sp_o       = sp_reg;
  assign flags_o    = {11'h000, flags_reg};

endmodule
`default_nettype wire

// *** tb/ddb_stack_mem.sv ***
// Behavioural stack memory that answers the execute unit
`timescale 1ns/1ps
`default_nettype none
module ddb_stack_mem (
  input  wire logic        clock_i, // Core clock
  input  wire logic        rst_b_i, // Async reset, active low
  input  wire logic [3:0]  wait_i,  // Wait cycles before each ack
  input  wire logic        req_i,   // Access pending
  input  wire logic        we_i,    // Write when high
  input  wire logic [15:0] addr_i,  // Byte address
  input  wire logic [15:0] wdata_i, // Write data
  output logic             ack_o,   // One-cycle completion pulse
  output logic [15:0]      rdata_o  // Read data, valid with ack
);
  logic [15:0] mem_words [0:255]; // Word store, address bits 8..1
  logic [3:0]  cnt;               // Cycles waited so far
  // Plain always so the bench may preload words directly
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt     <= 4'h0;
      ack_o   <= 1'b0;
      rdata_o <= 16'hA5A5;
    end else begin
      ack_o   <= 1'b0;
      // Scramble so stale read data never looks valid
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
        if (cnt == wait_i) begin
          cnt   <= 4'h0;
          ack_o <= 1'b1;
          if (we_i) mem_words[addr_i[8:1]] <= wdata_i;
          else rdata_o <= mem_words[addr_i[8:1]];
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/ddb_exec_monitor.sv ***
// Concurrent checks on the execute unit ports
`timescale 1ns/1ps
`default_nettype none
module ddb_exec_monitor
  import ddb_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic        instr_valid_i,
  input wire logic        instr_ready_o,
  input wire logic [15:0] instr_i,
  input wire logic [1:0]  instr_len_i,
  input wire logic [15:0] src_val_i,
  input wire logic [15:0] dst_val_i,
  input wire logic        src_byte_i,
  input wire logic        dst_byte_i,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [15:0] mem_wdata_o,
  input wire logic        mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  input wire logic        res_we_o,
  input wire logic [15:0] res_data_o,
  input wire logic        done_o,
  input wire logic [15:0] pc_o,
  input wire logic [15:0] sp_o,
  input wire logic [15:0] flags_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire        take = instr_valid_i && instr_ready_o; // Request accepted
  wire [3:0]  op   = instr_i[15:12];                 // Major opcode
  wire [3:0]  cc   = instr_i[11:8];                  // Predicate code
  wire        fabs = instr_i[7:6] == FMT_ABS;        // Absolute form
  // Byte operands seen with upper half cleared
  wire [15:0] src_x = src_byte_i ? src_val_i & BYTE_MASK : src_val_i;
  wire [15:0] dst_x = dst_byte_i ? dst_val_i & BYTE_MASK : dst_val_i;
  wire [15:0] seq_pc  = pc_o + {13'h0000, instr_len_i, 1'b0};
  wire [15:0] rel_off = {{8{instr_i[6]}}, instr_i[6:0], 1'b0};
  property p_copy;
    take && op == OP_COPY |=> res_we_o && res_data_o == $past(src_x)
      && flags_o == $past(flags_o);
  endproperty
  a_copy: assert property (p_copy) else $error("copy result bad");
  property p_sum;
    take && op == OP_SUM |=> res_data_o == $past(dst_x + src_x)
      && flags_o[FL_NULL] == (res_data_o == 16'h0000);
  endproperty
  a_sum: assert property (p_sum) else $error("sum result bad");
  property p_nowr;
    take && (op == OP_CMP || op == OP_PROBE) |=> !res_we_o;
  endproperty
  a_nowr: assert property (p_nowr) else $error("result written");
  property p_keep;
    take && (op == OP_AND || op == OP_PROBE || op == OP_OR || op == OP_XOR)
      |=> flags_o[2:1] == $past(flags_o[2:1]);
  endproperty
  a_keep: assert property (p_keep) else $error("flags moved");
  property p_rel;
    take && op == OP_JUMP && !instr_i[7] && cc == CC_ALWAYS
      |=> pc_o == $past(seq_pc + rel_off);
  endproperty
  a_rel: assert property (p_rel) else $error("relative target");
  property p_unused;
    take && op == OP_JUMP && cc == CC_UNUSED
      |=> pc_o == $past(seq_pc) && sp_o == $past(sp_o);
  endproperty
  a_unused: assert property (p_unused) else $error("code 14 moved");
  property p_push;
    take && op == OP_CALLT && fabs && cc == CC_ALWAYS |=> mem_req_o
      && mem_we_o && sp_o == $past(sp_o) - WORD_STEP && mem_addr_o == sp_o
      && mem_wdata_o == $past(seq_pc);
  endproperty
  a_push: assert property (p_push) else $error("call push bad");
  property p_hold;
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
      && $stable(mem_we_o);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_pop;
    mem_req_o && !mem_we_o && mem_ack_i
      |=> done_o && pc_o == $past(mem_rdata_i);
  endproperty
  a_pop: assert property (p_pop) else $error("popped pc bad");
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the execute unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ddb_pkg::*;
  typedef struct packed {
    logic [15:0] ins;
    logic [1:0]  ln;
    logic [15:0] src;
    logic [15:0] dst;
    logic [2:0]  fb;   // Source byte, destination byte, write
    logic [15:0] res;
    logic [3:0]  fl;
  } ddb_row_t;
  // Ordinary two-operand cases, flags carried from row to row
  ddb_row_t rows [0:10] = '{
    '{16'h0000, 2'h1, 16'h1234, 16'h0000, 3'h1, 16'h1234, 4'h0},
    '{16'h1000, 2'h2, 16'hFFFF, 16'h0001, 3'h1, 16'h0000, 4'h3},
    '{16'h2000, 2'h1, 16'h0001, 16'h0001, 3'h1, 16'h0003, 4'h0},
    '{16'h1000, 2'h1, 16'h80FF, 16'h7F01, 3'h5, 16'h8000, 4'hC},
    '{16'h3000, 2'h3, 16'h0002, 16'h0001, 3'h1, 16'hFFFF, 4'hA},
    '{16'h4000, 2'h1, 16'h0001, 16'h0005, 3'h1, 16'h0003, 4'h0},
    '{16'h5000, 2'h1, 16'h0001, 16'h8000, 3'h0, 16'h0000, 4'h4},
    '{16'h6000, 2'h1, 16'h8F0F, 16'hF0F0, 3'h1, 16'h8000, 4'hC},
    '{16'h7000, 2'h1, 16'h0F0F, 16'h00F0, 3'h0, 16'h0000, 4'h5},
    '{16'h8000, 2'h1, 16'h00F0, 16'hAB00, 3'h3, 16'h00F0, 4'h4},
    '{16'h9000, 2'h1, 16'h7FFF, 16'hFFFF, 3'h1, 16'h8000, 4'hC}};
  // Compare operands and the flags they leave
  logic [15:0] cd [0:3] = '{16'h0005, 16'h0001, 16'h8000, 16'h7FFF};
  logic [15:0] cs [0:3] = '{16'h0005, 16'h0002, 16'h0001, 16'hFFFF};
  logic [3:0]  cf [0:3] = '{4'h1, 4'hA, 4'h4, 4'hE};
  logic        clock_i, rst_b_i, instr_valid_i, instr_ready_o;
  logic [15:0] instr_i, src_val_i, dst_val_i, mem_addr_o, mem_wdata_o;
  logic [1:0]  instr_len_i;
  logic        src_byte_i, dst_byte_i, mem_req_o, mem_we_o, mem_ack_i;
  logic [15:0] mem_rdata_i, res_data_o, pc_o, sp_o, flags_o;
  logic        res_we_o, done_o;
  logic [3:0]  mem_wait;  // Partner answer delay
  logic [15:0] exp_pc;    // Expected program counter
  logic [6:0]  off;       // Relative offset under test
  ddb_row_t    r;
  int          n_fail, num_checks;
  ddb_exec uut (.*);
  ddb_stack_mem stack_mem (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .wait_i(mem_wait), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i),
    .rdata_o(mem_rdata_i));
  // Free-running 100 MHz clock
  always #5 clock_i = ~clock_i;
  // Reference predicate: codes 0..7 test one flag set or clear
  function automatic logic pred(input logic [3:0] c, input logic [3:0] f);
    logic [3:0] v;
    v = {f[2], f[3], f[1], f[0]};
    case (c)
      4'h8: pred = !f[0] && !f[1];
      4'h9: pred = f[0] || f[1];
      4'hA: pred = (f[2] == f[3]) && !f[0];
      4'hB: pred = f[2] == f[3];
      4'hC: pred = f[2] != f[3];
      4'hD: pred = (f[2] != f[3]) || f[0];
      4'hE: pred = 1'b0;
      4'hF: pred = 1'b1;
      default: pred = v[c[2:1]] ^ c[0];
    endcase
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // Present one instruction; back at the negedge after the take
  task automatic issue(input logic [15:0] ins, input logic [1:0] ln,
    input logic [15:0] s, d, input logic sb = 1'b0, db = 1'b0);
    int k;
    k = 0;
    {instr_i, instr_len_i, src_val_i, dst_val_i, src_byte_i, dst_byte_i} =
      {ins, ln, s, d, sb, db};
    instr_valid_i = 1'b1;
    while (instr_ready_o !== 1'b1 && k < 50) begin
      @(negedge clock_i);
      k++;
    end
    @(negedge clock_i);
  endtask
  // Drop the request, wait for retirement
  task automatic finish_op();
    int k;
    k = 0;
    instr_valid_i = 1'b0;
    @(negedge clock_i);
    while (done_o !== 1'b1 && k < 50) begin
      @(negedge clock_i);
      k++;
    end
    chk("done", 16'h0001, 16'(done_o));
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
  initial begin
    clock_i = 1'b0;
    rst_b_i = 1'b0;
    instr_valid_i = 1'b0;
    {instr_i, src_val_i, dst_val_i, instr_len_i, src_byte_i, dst_byte_i} = '0;
    mem_wait = 4'h0;
    n_fail = 0;
    num_checks = 0;
    exp_pc = 16'h0000;
    stack_mem.mem_words[8'h28] = 16'h0ABC;
    repeat (20) @(negedge clock_i);
    chk("ready", 16'h0001, 16'(instr_ready_o));
    rst_b_i = 1'b1;
    // Table rows issued back to back
    foreach (rows[i]) begin
      r = rows[i];
      issue(r.ins, r.ln, r.src, r.dst, r.fb[2], r.fb[1]);
      exp_pc += {13'h0000, r.ln, 1'b0};
      chk("done", 16'h0001, 16'(done_o));
      chk("res_we", 16'(r.fb[0]), 16'(res_we_o));
      if (r.fb[0]) chk("res", r.res, res_data_o);
      chk("flags", 16'(r.fl), flags_o);
      chk("pc", exp_pc, pc_o);
    end
    // Every predicate code against four flag states, both offset ends
    for (int j = 0; j < 4; j++) begin
      issue(16'h5000, 2'h1, cs[j], cd[j]);
      exp_pc += 16'h0002;
      chk("cmp_flags", 16'(cf[j]), flags_o);
      for (int c = 0; c < 16; c++) begin
        off = c[0] ? 7'h40 : 7'h3F;
        issue({4'hC, c[3:0], 1'b0, off}, 2'h1, 16'h0, 16'h0);
        exp_pc += 16'h0002;
        if (pred(c[3:0], cf[j])) exp_pc += {{8{off[6]}}, off, 1'b0};
        chk("pc", exp_pc, pc_o);
      end
    end
    // Absolute jump, then untaken jump and return with extension skip
    issue(16'hCF80, 2'h1, 16'h0000, 16'h1234);
    chk("pc", 16'h1234, pc_o);
    issue(16'hC080, 2'h2, 16'h0000, 16'h4444);
    chk("pc", 16'h1238, pc_o);
    issue(16'hC097, 2'h1, 16'h0000, 16'h0000);
    chk("pc", 16'h123A, pc_o);
    chk("sp", 16'h0000, sp_o);
    // Call with a prompt partner
    issue(16'hAF80, 2'h1, 16'h0000, 16'h0400);
    finish_op();
    chk("pc", 16'h0400, pc_o);
    chk("sp", 16'hFFFE, sp_o);
    chk("push", 16'h123C, stack_mem.mem_words[8'hFF]);
    // Return with a slow partner
    mem_wait = 4'h3;
    issue(16'hCF97, 2'h1, 16'h0000, 16'h0000);
    finish_op();
    chk("pc", 16'h123C, pc_o);
    chk("sp", 16'h0000, sp_o);
    // Software trap on vector 40, clear of the hardware range
    mem_wait = 4'h1;
    issue(16'hA028, 2'h1, 16'h0000, 16'h0000);
    finish_op();
    chk("pc", 16'h0ABC, pc_o);
    chk("sp", 16'hFFFE, sp_o);
    chk("push", 16'h123E, stack_mem.mem_words[8'hFF]);
    chk("flags", 16'h000E, flags_o);
    // Reset in mid-run, then a copy on the first edge after release
    rst_b_i = 1'b0;
    @(negedge clock_i);
    chk("pc", 16'h0000, pc_o);
    chk("sp", 16'h0000, sp_o);
    chk("flags", 16'h0000, flags_o);
    rst_b_i = 1'b1;
    issue(16'h0000, 2'h1, 16'h5AC3, 16'h0000, 1'b1);
    chk("res", 16'h00C3, res_data_o);
    chk("flags", 16'h0000, flags_o);
    instr_valid_i = 1'b0;
    @(negedge clock_i);
    wrap_up();
  end
endmodule
bind ddb_exec ddb_exec_monitor mon (.*);
`default_nettype wire
